// ### shared/lmc_defs.vh
// Constants for the sequencer mode and run control register bank
`ifndef LMC_DEFS_VH
`define LMC_DEFS_VH

// ==========================================================
// Register offsets
`define LMC_ADDR_CTRL      8'h00
`define LMC_ADDR_MODE      8'h01
`define LMC_ADDR_DIM_HI    8'h02
`define LMC_ADDR_DIM_LO    8'h03
`define LMC_ADDR_PC1       8'h37
`define LMC_ADDR_PC2       8'h38
`define LMC_ADDR_PC3       8'h39
`define LMC_ADDR_BUSY      8'h3a

// ==========================================================
// Field positions and reset values
`define LMC_CHIP_EN_BIT    6
`define LMC_CTRL_RST       7'h00
`define LMC_MODE_RST       6'h00
`define LMC_DIM_RST        9'h000

// ==========================================================
// Run field encodings
`define LMC_EXEC_HOLD      2'h0
`define LMC_EXEC_STEP      2'h1
`define LMC_EXEC_FREE      2'h2
`define LMC_EXEC_ONCE      2'h3

// ==========================================================
// Operating state encodings
`define LMC_MODE_DIS       2'h0
`define LMC_MODE_LOAD      2'h1
`define LMC_MODE_RUN       2'h2
`define LMC_MODE_HALT      2'h3

// ==========================================================
// Program counter
`define LMC_PC_W           7
`define LMC_PC_LAST        7'h7f
`define LMC_PC_ZERO        7'h00
`define LMC_PC_ONE         7'h01

`endif

// ### rtl/lmc_seq_ctrl.v
// Per-sequencer instruction launch state machine and program counter
`timescale 1ns/100ps
`include "lmc_defs.vh"

module lmc_seq_ctrl (
    // Clock and reset
    input  wire                 clk_i,
    input  wire                 rst_i,
    // Control fields
    input  wire [1:0]           exec_i,
    input  wire [1:0]           mode_i,
    input  wire                 mode_wr_i,
    input  wire                 load_any_i,
    input  wire                 pc_clr_i,
    input  wire                 pc_wr_i,
    input  wire [6:0]           pc_wdata_i,
    // Instruction executor
    input  wire                 done_i,
    output wire                 go_o,
    output wire                 abort_o,
    output wire                 clr_exec_o,
    output wire                 busy_o,
    output wire [6:0]           pc_o
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_BUSY = 3'b010;
    localparam [2:0] ST_HALT = 3'b100;

    reg [2:0]  st_q;
    reg [2:0]  st_d;
    reg [1:0]  kind_q;
    reg [6:0]  pc_q;
    reg [6:0]  pc_d;
    wire       run_ok;
    wire       halt_now;
    wire       start;
    wire       fin;
    wire [6:0] pc_inc;

    // Nothing launches while any sequencer is loading
    assign run_ok   = (mode_i == `LMC_MODE_RUN) & ~load_any_i;
    assign halt_now = (mode_i == `LMC_MODE_HALT) & (st_q != ST_HALT);
    assign start    = (st_q == ST_IDLE) & run_ok & ~halt_now
                      & (exec_i != `LMC_EXEC_HOLD);
    assign fin      = (st_q == ST_BUSY) & done_i & ~halt_now;
    assign go_o     = start;
    assign abort_o  = halt_now;
    assign clr_exec_o = fin & ((kind_q == `LMC_EXEC_STEP)
                      | (kind_q == `LMC_EXEC_ONCE));
    assign busy_o   = (st_q == ST_BUSY);
    assign pc_o     = pc_q;
    assign pc_inc   = (pc_q == `LMC_PC_LAST) ? `LMC_PC_ZERO
                      : pc_q + `LMC_PC_ONE;

    always @*
    begin
        st_d = st_q;
        case (st_q)
            ST_IDLE:
            begin
                if (halt_now)
                    st_d = ST_HALT;
                else if (start)
                    st_d = ST_BUSY;
            end
            ST_BUSY:
            begin
                // A halt takes effect at once; a hold only after the current instruction
                if (halt_now)
                    st_d = ST_HALT;
                else if (done_i)
                    st_d = ST_IDLE;
            end
            ST_HALT:
            begin
                if (mode_wr_i)
                    st_d = ST_IDLE;
            end
            default:
                st_d = ST_IDLE;
        endcase
    end

    always @*
    begin
        pc_d = pc_q;
        if (pc_clr_i)
            pc_d = `LMC_PC_ZERO;
        else if (pc_wr_i)
            pc_d = pc_wdata_i;
        else if (fin && kind_q != `LMC_EXEC_ONCE)
            pc_d = pc_inc;
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q   <= ST_IDLE;
            kind_q <= `LMC_EXEC_HOLD;
            pc_q   <= `LMC_PC_ZERO;
        end
        else
        begin
            st_q <= st_d;
            pc_q <= pc_d;
            if (start)
                kind_q <= exec_i;
        end
    end

endmodule

// ### rtl/lmc_top.v
// Sequencer mode, run control and proportional dimming register bank
`timescale 1ns/100ps
`include "lmc_defs.vh"

module lmc_top (
    // Clock and reset
    input  wire                 MCLK_I,
    input  wire                 RST_I,
    // Register port from the serial bus front end
    input  wire                 REG_WR_I,
    input  wire                 REG_RD_I,
    input  wire [7:0]           REG_ADDR_I,
    input  wire [7:0]           REG_WDATA_I,
    output wire [7:0]           REG_RDATA_O,
    // Program memory write qualification
    input  wire                 PROG_WR_I,
    output wire                 PROG_WR_OK_O,
    // Instruction executor, bit 0 is the first sequencer
    input  wire [2:0]           ENG_DONE_I,
    output wire [2:0]           ENG_GO_O,
    output wire [2:0]           ENG_ABORT_O,
    output wire [20:0]          ENG_PC_O,
    // Status and control levels
    output wire                 CHIP_EN_O,
    output wire                 LOAD_HOLD_O,
    output wire [8:0]           DIM_EN_O,
    // PWM duty path, output n at bits 8n+7:8n
    input  wire [7:0]           FADE_LEVEL_I,
    input  wire [71:0]          PWM_DUTY_I,
    output wire [71:0]          PWM_DUTY_O
);

    // ======================================================
    // Register storage
    reg  [6:0]  ctrl_q;
    reg  [6:0]  ctrl_d;
    reg  [5:0]  mode_q;
    wire [5:0]  mode_d;
    reg  [8:0]  dim_q;
    reg  [7:0]  rdata_q;
    reg  [7:0]  rdata_d;
    reg  [71:0] pwm_q;
    wire [71:0] pwm_d;

    wire        chip_en;
    wire        wr_ctrl;
    wire        wr_mode;
    wire        load_any;
    wire [2:0]  load_vec;
    wire [2:0]  busy_vec;
    wire [2:0]  clr_exec;
    wire [2:0]  pc_clr;
    wire [2:0]  pc_ok;
    wire [20:0] pc_all;

    assign chip_en  = ctrl_q[`LMC_CHIP_EN_BIT];
    assign wr_ctrl  = REG_WR_I & (REG_ADDR_I == `LMC_ADDR_CTRL);
    assign wr_mode  = REG_WR_I & (REG_ADDR_I == `LMC_ADDR_MODE);
    assign load_any = |load_vec;

    // ======================================================
    // Per-sequencer fields and state machines
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1)
        begin : g_seq
            // First sequencer sits in the high field of the control and mode registers
            localparam integer HI = 5 - 2 * i;
            localparam integer LO = 4 - 2 * i;
            wire [7:0] pc_addr;
            wire [1:0] exec_f;
            wire [1:0] mode_f;
            wire [1:0] mode_new;
            wire       pc_wr;

            assign pc_addr  = (i == 0) ? `LMC_ADDR_PC1 :
                              (i == 1) ? `LMC_ADDR_PC2 :
                              `LMC_ADDR_PC3;
            assign exec_f   = ctrl_q[HI:LO];
            assign mode_f   = mode_q[HI:LO];
            assign mode_new = REG_WDATA_I[HI:LO];
            assign load_vec[i] = (mode_f == `LMC_MODE_LOAD);
            assign pc_ok[i] = (exec_f == `LMC_EXEC_HOLD);

            // Load mode only from disabled; a refused write keeps the field
            assign mode_d[HI:LO] =
                (!wr_mode) ? mode_f :
                (mode_new == `LMC_MODE_LOAD &&
                 mode_f != `LMC_MODE_DIS) ? mode_f : mode_new;
            assign pc_clr[i] = wr_mode & (mode_new == `LMC_MODE_LOAD)
                               & (mode_f == `LMC_MODE_DIS);

            // Counter writes need normal mode and a held sequencer
            assign pc_wr = REG_WR_I & (REG_ADDR_I == pc_addr) & chip_en
                           & pc_ok[i] & ~busy_vec[i];

            lmc_seq_ctrl u_seq (
                .clk_i      (MCLK_I),
                .rst_i      (RST_I),
                .exec_i     (exec_f),
                .mode_i     (mode_f),
                .mode_wr_i  (wr_mode),
                .load_any_i (load_any),
                .pc_clr_i   (pc_clr[i]),
                .pc_wr_i    (pc_wr),
                .pc_wdata_i (REG_WDATA_I[6:0]),
                .done_i     (ENG_DONE_I[i]),
                .go_o       (ENG_GO_O[i]),
                .abort_o    (ENG_ABORT_O[i]),
                .clr_exec_o (clr_exec[i]),
                .busy_o     (busy_vec[i]),
                .pc_o       (pc_all[7*i+6:7*i])
            );
        end
    endgenerate

    assign ENG_PC_O = pc_all;

    // ======================================================
    // Control register next value
    always @*
    begin
        ctrl_d = ctrl_q;
        // Self-clear of step and execute-once back to hold
        if (clr_exec[0])
            ctrl_d[5:4] = `LMC_EXEC_HOLD;
        if (clr_exec[1])
            ctrl_d[3:2] = `LMC_EXEC_HOLD;
        if (clr_exec[2])
            ctrl_d[1:0] = `LMC_EXEC_HOLD;
        if (wr_ctrl)
        begin
            ctrl_d[`LMC_CHIP_EN_BIT] = REG_WDATA_I[`LMC_CHIP_EN_BIT];
            // In standby the run fields ignore writes
            if (chip_en)
                ctrl_d[5:0] = REG_WDATA_I[5:0];
        end
    end

    // ======================================================
    // Read data mux
    always @*
    begin
        case (REG_ADDR_I)
            `LMC_ADDR_CTRL:
                rdata_d = {1'b0, ctrl_q};
            `LMC_ADDR_MODE:
                rdata_d = {2'h0, mode_q};
            `LMC_ADDR_DIM_HI:
                rdata_d = {7'h00, dim_q[8]};
            `LMC_ADDR_DIM_LO:
                rdata_d = dim_q[7:0];
            // A running counter is not visible; it reads as zero
            `LMC_ADDR_PC1:
                rdata_d = pc_ok[0] ? {1'b0, pc_all[6:0]} : 8'h00;
            `LMC_ADDR_PC2:
                rdata_d = pc_ok[1] ? {1'b0, pc_all[13:7]} : 8'h00;
            `LMC_ADDR_PC3:
                rdata_d = pc_ok[2] ? {1'b0, pc_all[20:14]} : 8'h00;
            `LMC_ADDR_BUSY:
                rdata_d = {5'h00, busy_vec};
            default:
                rdata_d = 8'h00;
        endcase
    end

    // ======================================================
    // Program memory write gate
    // The host is expected to poll the busy flag first; a write that
    // arrives while busy is simply dropped.
    assign PROG_WR_OK_O = PROG_WR_I & load_any
                          & ~(|busy_vec);

    // ======================================================
    // Proportional dimming of PWM duty
    // Scaling by a common level keeps the ratio between enabled outputs.
    genvar j;
    generate
        for (j = 0; j < 9; j = j + 1)
        begin : g_dim
            wire [7:0]  duty;
            wire [15:0] prod;

            assign duty = PWM_DUTY_I[8*j+7:8*j];
            assign prod = duty * FADE_LEVEL_I;
            assign pwm_d[8*j+7:8*j] = dim_q[j] ? prod[15:8]
                                      : duty;
        end
    endgenerate

    // ======================================================
    // Registers
    always @(posedge MCLK_I)
    begin
        if (RST_I)
        begin
            ctrl_q  <= `LMC_CTRL_RST;
            mode_q  <= `LMC_MODE_RST;
            dim_q   <= `LMC_DIM_RST;
            rdata_q <= 8'h00;
            pwm_q   <= 72'h0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            mode_q <= mode_d;
            if (REG_WR_I && REG_ADDR_I == `LMC_ADDR_DIM_HI)
                dim_q[8] <= REG_WDATA_I[0];
            if (REG_WR_I && REG_ADDR_I == `LMC_ADDR_DIM_LO)
                dim_q[7:0] <= REG_WDATA_I;
            if (REG_RD_I)
                rdata_q <= rdata_d;
            // Duty values freeze while any sequencer loads
            if (!load_any)
                pwm_q <= pwm_d;
        end
    end

    // ======================================================
    // Outputs
    assign REG_RDATA_O = rdata_q;
    assign CHIP_EN_O   = chip_en;
    assign LOAD_HOLD_O = load_any;
    assign DIM_EN_O    = dim_q;
    assign PWM_DUTY_O  = pwm_q;

endmodule

// ### tb/lmc_top_chk.sv
// Assertion checker for the sequencer control register bank
`timescale 1ns/100ps
module lmc_top_chk (
    input wire logic        MCLK_I,
    input wire logic        RST_I,
    input wire logic        REG_WR_I,
    input wire logic [7:0]  REG_ADDR_I,
    input wire logic [7:0]  REG_WDATA_I,
    input wire logic        PROG_WR_I,
    input wire logic        PROG_WR_OK_O,
    input wire logic [2:0]  ENG_DONE_I,
    input wire logic [2:0]  ENG_GO_O,
    input wire logic [2:0]  ENG_ABORT_O,
    input wire logic [20:0] ENG_PC_O,
    input wire logic        CHIP_EN_O,
    input wire logic        LOAD_HOLD_O,
    input wire logic [8:0]  DIM_EN_O,
    input wire logic [71:0] PWM_DUTY_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    // ==========================================================
    // Sequences
    sequence no_mode_wr_s;
        (!(REG_WR_I && REG_ADDR_I == 8'h01))[*3];
    endsequence
    // ==========================================================
    // Properties
    no_go_load_a: assert property (
        LOAD_HOLD_O |-> ENG_GO_O == 3'h0) else $error("launch in load");
    pwm_freeze_a: assert property (
        LOAD_HOLD_O |=> $stable(PWM_DUTY_O)) else $error("duty moved");
    prog_ok_a: assert property (
        PROG_WR_OK_O |-> PROG_WR_I && LOAD_HOLD_O) else $error("bad prog ok");
    go_single_a: assert property (
        ENG_GO_O[0] |=> !ENG_GO_O[0]) else $error("launch too long");
    halt_stop_a: assert property (
        ENG_ABORT_O[0] ##0 no_mode_wr_s |=> !ENG_GO_O[0])
        else $error("launch while halted");
    pc_step_a: assert property (
        ENG_DONE_I[0] && !REG_WR_I |=>
        ENG_PC_O[6:0] - $past(ENG_PC_O[6:0]) <= 7'h01)
        else $error("counter jump");
    pc_cause_a: assert property (
        !$stable(ENG_PC_O) |-> $past(ENG_DONE_I != 3'h0 || REG_WR_I || RST_I))
        else $error("counter moved alone");
    dim_wr_a: assert property (
        REG_WR_I && REG_ADDR_I == 8'h03 |=> DIM_EN_O[7:0] == $past(REG_WDATA_I))
        else $error("dim write lost");
    chip_en_a: assert property (
        !$stable(CHIP_EN_O) |-> $past(REG_WR_I && REG_ADDR_I == 8'h00))
        else $error("enable moved alone");
endmodule
bind lmc_top lmc_top_chk u_chk (
    .MCLK_I(MCLK_I), .RST_I(RST_I), .REG_WR_I(REG_WR_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
    .PROG_WR_I(PROG_WR_I), .PROG_WR_OK_O(PROG_WR_OK_O),
    .ENG_DONE_I(ENG_DONE_I), .ENG_GO_O(ENG_GO_O),
    .ENG_ABORT_O(ENG_ABORT_O), .ENG_PC_O(ENG_PC_O), .CHIP_EN_O(CHIP_EN_O),
    .LOAD_HOLD_O(LOAD_HOLD_O), .DIM_EN_O(DIM_EN_O), .PWM_DUTY_O(PWM_DUTY_O)
);

// ### tb/lmc_exec_model.sv
// Instruction executor model answering launch pulses after a delay
`timescale 1ns/100ps
module lmc_exec_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       slow_i,
    input  wire logic [2:0] go_i,
    input  wire logic [2:0] abort_i,
    output logic [2:0]      done_o
);
    // ==========================================================
    // Countdown per sequencer; slow mode lets a halt land mid-way
    int cnt [3];
    initial done_o = 3'h0;
    always @(posedge clk_i)
    begin
        for (int i = 0; i < 3; i++)
        begin
            done_o[i] <= 1'b0;
            if (rst_i || abort_i[i])
                cnt[i] <= 0;
            else if (go_i[i])
                cnt[i] <= slow_i ? 6 : 1;
            else if (cnt[i] == 1)
            begin
                done_o[i] <= 1'b1;
                cnt[i] <= 0;
            end
            else if (cnt[i] > 1)
                cnt[i] <= cnt[i] - 1;
        end
    end
endmodule

// ### tb/lmc_top_tb.sv
// Self-checking bench for the sequencer control register bank
`timescale 1ns/100ps
module lmc_top_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wr = 1'b0, rd = 1'b0, prog_wr = 1'b0, slow = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, fade = 8'h80;
    logic        prog_ok, chip_en, load_hold;
    logic [2:0]  done, go, abort, abort_seen = 3'h0;
    logic [20:0] pc;
    logic [8:0]  dim_en;
    logic [71:0] duty = {9{8'h64}}, duty_o;
    int          num_errors = 0, n_checks = 0, cyc = 0;

    always #12.5 clk = ~clk;
    always @(posedge clk) abort_seen <= abort_seen | abort;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    lmc_top u_dut (
        .MCLK_I(clk), .RST_I(rst), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
        .PROG_WR_I(prog_wr), .PROG_WR_OK_O(prog_ok), .ENG_DONE_I(done),
        .ENG_GO_O(go), .ENG_ABORT_O(abort), .ENG_PC_O(pc),
        .CHIP_EN_O(chip_en), .LOAD_HOLD_O(load_hold), .DIM_EN_O(dim_en),
        .FADE_LEVEL_I(fade), .PWM_DUTY_I(duty), .PWM_DUTY_O(duty_o)
    );
    lmc_exec_model u_exec (
        .clk_i(clk), .rst_i(rst), .slow_i(slow), .go_i(go),
        .abort_i(abort), .done_o(done)
    );

    // ==========================================================
    // Bus helpers; every task starts and ends just after an edge
    task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        wr = 1'b1;
        addr = a;
        wdata = d;
        ticks(1);
        wr = 1'b0;
        // Let an edge pass so a following write never re-raises the strobe
        ticks(1);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        rd = 1'b1;
        addr = a;
        ticks(1);
        rd = 1'b0;
        ticks(1);
        d = rdata;
    endtask
    task automatic prog_try(input logic exp);
        prog_wr = 1'b1;
        #1 chk(prog_ok, exp);
        ticks(1);
        prog_wr = 1'b0;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_standby();
        logic [7:0] v;
        for (int a = 0; a < 5; a++)
        begin
            rd_reg(a == 4 ? 8'h10 : a[7:0], v);
            chk(v, 8'h00);
        end
        wr_reg(8'h00, 8'h3f);
        chk(chip_en, 1'b0);
        wr_reg(8'h37, 8'h11);
        wr_reg(8'h00, 8'h40);
        chk(chip_en, 1'b1);
        rd_reg(8'h00, v);
        chk(v, 8'h40);
        rd_reg(8'h37, v);
        chk(v, 8'h00);
        prog_try(1'b0);
    endtask
    task automatic t_step();
        logic [7:0] v;
        int sh;
        for (int i = 0; i < 3; i++)
        begin
            sh = 4 - 2 * i;
            wr_reg(8'h37 + i[7:0], 8'h7f);
            rd_reg(8'h37 + i[7:0], v);
            chk(v, 8'h7f);
            wr_reg(8'h00, 8'h40 | (8'h01 << sh));
            wr_reg(8'h01, 8'h02 << sh);
            v = 8'hff;
            for (int k = 0; k < 20 && v != 8'h40; k++)
                rd_reg(8'h00, v);
            chk(v, 8'h40);
            chk(pc[7*i +: 7], 7'h00);
            wr_reg(8'h00, 8'h40 | (8'h03 << sh));
            ticks(6);
            chk(pc[7*i +: 7], 7'h00);
            rd_reg(8'h00, v);
            chk(v, 8'h40);
            wr_reg(8'h01, 8'h00);
        end
    endtask
    task automatic t_halt();
        logic [7:0] v;
        logic [6:0] p0;
        slow = 1'b1;
        wr_reg(8'h00, 8'h60);
        wr_reg(8'h01, 8'h20);
        ticks(20);
        rd_reg(8'h37, v);
        chk(v, 8'h00);
        chk(pc[6:0] != 7'h00, 1'b1);
        wr_reg(8'h01, 8'h10);
        rd_reg(8'h01, v);
        chk(v, 8'h20);
        chk(abort_seen, 3'h0);
        wr_reg(8'h01, 8'h30);
        ticks(2);
        chk(abort_seen, 3'h1);
        p0 = pc[6:0];
        ticks(15);
        chk(pc[6:0], p0);
        wr_reg(8'h01, 8'h20);
        ticks(15);
        chk(pc[6:0] != p0, 1'b1);
        wr_reg(8'h01, 8'h00);
        wr_reg(8'h00, 8'h40);
        slow = 1'b0;
    endtask
    task automatic t_freeze();
        logic [7:0] v;
        wr_reg(8'h02, 8'h01);
        wr_reg(8'h03, 8'h01);
        chk(dim_en, 9'h101);
        ticks(2);
        chk(duty_o, {8'h32, {7{8'h64}}, 8'h32});
        wr_reg(8'h38, 8'h05);
        chk(pc[13:7], 7'h05);
        wr_reg(8'h01, 8'h04);
        chk(pc[13:7], 7'h00);
        chk(load_hold, 1'b1);
        // Host polls the busy flags before touching program memory
        rd_reg(8'h3a, v);
        chk(v, 8'h00);
        prog_try(1'b1);
        duty = {9{8'h20}};
        ticks(3);
        chk(duty_o, {8'h32, {7{8'h64}}, 8'h32});
        wr_reg(8'h01, 8'h00);
        ticks(2);
        chk(duty_o, {8'h10, {7{8'h20}}, 8'h10});
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        ticks(4);
        rst = 1'b0;
        t_standby();
        t_step();
        t_halt();
        t_freeze();
        tally_and_finish();
    end
endmodule
